// File: core/mgqc_rule_table.sv
`timescale 1ns/10ps
module mgqc_rule_table import mgqc_pkg::*; #(
   parameter int NR = NRULE
) (
   input wire logic clk,
   input wire logic rst_n,
   mgqc_rule_if.tbl rif
);

   if (NR < 1 || NR > NRULE) begin : g_chk
      $error("mgqc_rule_table: NR out of range");
   end

   // ==========================================================
   // Storage
   logic [31:0] wa_r [NR];
   logic [31:0] wb_r [NR];
   logic [7:0] cnt_r [NR];
   logic [NR-1:0] m;
   logic [RIW-1:0] pick;
   logic found;
   logic hit_r;
   logic [7:0] flow_r;
   logic refused_r;
   logic [31:0] rd_r;

   function automatic logic ds_in(input logic [7:0] ds, input logic [31:0] wb);
      logic [7:0] v;
      v = ds & wb[RB_MASK_LSB +: 8];
      return (v >= wb[RB_LO_LSB +: 8]) && (v <= wb[RB_HI_LSB +: 8]);
   endfunction : ds_in

   // ==========================================================
   // Session and scrub decode
   wire [31:0] ses_wa = wa_r[rif.ses_idx];
   wire [7:0] ses_cnt = cnt_r[rif.ses_idx];
   wire [7:0] ses_lim = ses_wa[RA_AGG] ? rif.cap : 8'h01;
   wire ses_ok = ses_wa[RA_VALID] && (rif.ses_join ? ses_cnt < ses_lim : ses_cnt != 8'h00);
   wire [31:0] scr_wa = wa_r[rif.scr_idx];
   wire scr_exact = scr_wa[RA_SRC_LSB +: 8] != 8'h00 && scr_wa[RA_GRP_LSB +: 8] != 8'h00;
   wire scr_del = rif.scr_en && (cnt_r[rif.scr_idx] == 8'h00
                  || (!scr_wa[RA_AGG] && !scr_exact) || scr_wa[RA_FLOW_LSB +: 8] == 8'h00);

   // ==========================================================
   // Entries
   for (genvar i = 0; i < NR; i++) begin : g_ent
      wire src_ok = wa_r[i][RA_SRC_LSB +: 8] == 8'h00 || wa_r[i][RA_SRC_LSB +: 8] == rif.mt_src;
      wire grp_ok = wa_r[i][RA_GRP_LSB +: 8] == 8'h00 || wa_r[i][RA_GRP_LSB +: 8] == rif.mt_grp;
      wire me_wr = rif.wr_en && rif.wr_idx == RIW'(i);
      wire me_ses = rif.ses_en && ses_ok && rif.ses_idx == RIW'(i);
      wire me_del = scr_del && rif.scr_idx == RIW'(i);
      // Aggregate rules hold wildcards, single rules an exact pair
      assign m[i] = wa_r[i][RA_VALID] && src_ok && grp_ok && ds_in(rif.mt_ds, wb_r[i]); // [R18] [R7] [R8]

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            wa_r[i] <= 32'h0000_0000;
            wb_r[i] <= 32'h0000_0000;
         end else if (me_wr) begin
            if (rif.wr_word) wb_r[i] <= rif.wr_data;
            else wa_r[i] <= rif.wr_data;
         end else if (me_del) begin
            wa_r[i][RA_VALID] <= 1'b0; // [R9]
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) cnt_r[i] <= 8'h00;
         else if (me_ses) cnt_r[i] <= rif.ses_join ? cnt_r[i] + 8'h01 : cnt_r[i] - 8'h01; // [R10]
         else if (me_del) cnt_r[i] <= 8'h00;
      end
   end

   // ==========================================================
   // Lowest index wins
   always_comb begin
      pick = '0;
      found = 1'b0;
      for (int k = NR - 1; k >= 0; k--) begin
         if (m[k]) begin
            pick = RIW'(k);
            found = 1'b1;
         end
      end
   end

   wire [31:0] rd_sel = rif.rd_word == RD_CNT ? {24'h00_0000, cnt_r[rif.rd_idx]} :
                        rif.rd_word == RD_B ? wb_r[rif.rd_idx] : wa_r[rif.rd_idx];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_r <= 1'b0;
         flow_r <= 8'h00;
         refused_r <= 1'b0;
         rd_r <= 32'h0000_0000;
      end else begin
         hit_r <= rif.mt_en && found;
         flow_r <= wa_r[pick][RA_FLOW_LSB +: 8];
         refused_r <= rif.ses_en && !ses_ok; // [R10]
         rd_r <= rd_sel;
      end
   end

   assign rif.hit = hit_r;
   assign rif.hit_flow = flow_r;
   assign rif.ses_refused = refused_r;
   assign rif.rd_data = rd_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_ds_miss: assert property (rif.mt_en && !(|m) |=> !rif.hit) // [R1]
      else $error("packet outside every DS range was classified");
   a_join_cap: assert property (rif.ses_en && rif.ses_join && !ses_ok // [R10]
      |=> rif.ses_refused && cnt_r[$past(rif.ses_idx)] == $past(ses_cnt))
      else $error("join over session cap was accepted");
   a_scrub_del: assert property (scr_del && !rif.wr_en // [R9]
      |=> !wa_r[$past(rif.scr_idx)][RA_VALID])
      else $error("unneeded rule survived scrub");

endmodule : mgqc_rule_table

// File: core/mgqc_top.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
// Behaviour
// R1 - DS value six matches only its rule
// R2 - One service class named default group class
// R3 - Unmatched multicast uses default group flow
// R4 - Unmatched traffic only on single channels
// R5 - Every channel owns one default flow
// R6 - Default class rate caps unclassified traffic
// R7 - Aggregate rule maps whole range shared
// R8 - Single rule maps exact pair dedicated
// R9 - Unneeded rules and flows get deleted; the scrub clears rule valid bits and session counts, and flows are not deleted
// R10 - Aggregate sessions never exceed session cap
// R11 - Class changes may update derived flows
// R12 - Tables govern only joined sessions
// R13 - Layer two traffic rides some group flow
// R14 - Extra rules allowed for other traffic
// R15 - Flow tree strict, one parent each
// R16 - Modem passes settings through uninterpreted
// R17 - Modem polices requests per flow only
// R18 - DS range match by mask then bounds
module mgqc_top import mgqc_pkg::*; #(
   parameter int NR = NRULE,
   parameter int NC = NCH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pkt_valid,
   output logic pkt_ready,
   input wire logic [1:0] pkt_kind,
   input wire logic [7:0] pkt_src,
   input wire logic [7:0] pkt_grp,
   input wire logic [7:0] pkt_ds,
   input wire logic [15:0] pkt_len,
   input wire logic [CHW-1:0] pkt_chan,
   input wire logic pkt_bonded,
   output logic out_valid,
   output logic [7:0] out_flow,
   output logic out_default,
   output logic out_drop,
   output logic [CHW-1:0] out_chan
);

   if (NC < 1 || NC > NCH || NR < 1 || NR > NRULE) begin : g_chk
      $error("mgqc_top: size parameter out of range");
   end

   // ==========================================================
   // APB decode
   mgqc_rule_if rif ();

   logic [31:0] ctrl_r;
   logic [31:0] defc_r;
   logic [31:0] flows_r;
   logic [31:0] cap_r;
   logic refused_r;
   logic [31:0] drops_r;
   logic [31:0] reg_rd_r;

   wire apb_setup = psel && !penable;
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire in_rule = paddr >= A_RULE && paddr < A_RULE_END;
   wire in_cnt = paddr >= A_CNT && paddr < A_CNT_END;
   wire in_regs = paddr == A_CTRL || paddr == A_DEFC || paddr == A_FLOWS
                  || paddr == A_SESS || paddr == A_DROPS || paddr == A_CAP;
   wire mapped = paddr[1:0] == 2'h0 && (in_rule || in_cnt || in_regs);

   assign pready = 1'b1;
   assign pslverr = apb_acc && !mapped;
   assign prdata = (in_rule || in_cnt) ? rif.rd_data : reg_rd_r;

   assign rif.wr_en = apb_wr && in_rule && paddr[1:0] == 2'h0;
   assign rif.wr_word = paddr[2];
   assign rif.wr_idx = paddr[3 +: RIW];
   assign rif.wr_data = pwdata;
   assign rif.rd_idx = in_cnt ? paddr[2 +: RIW] : paddr[3 +: RIW];
   assign rif.rd_word = in_cnt ? RD_CNT : (paddr[2] ? RD_B : RD_A);
   assign rif.ses_en = apb_wr && paddr == A_SESS;
   assign rif.ses_join = pwdata[SC_JOIN];
   assign rif.ses_idx = pwdata[RIW-1:0];
   assign rif.cap = cap_r[7:0];

   wire [31:0] reg_rd_nxt = paddr == A_CTRL ? ctrl_r :
                            paddr == A_DEFC ? defc_r :
                            paddr == A_FLOWS ? flows_r :
                            paddr == A_SESS ? {31'h0000_0000, refused_r} :
                            paddr == A_DROPS ? drops_r :
                            paddr == A_CAP ? cap_r : 32'h0000_0000;

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         defc_r <= DEFC_RST;
         flows_r <= FLOWS_RST;
         cap_r <= CAP_RST;
      end else if (apb_wr) begin
         if (paddr == A_CTRL) ctrl_r <= pwdata & 32'h0000_0001;
         if (paddr == A_DEFC) defc_r <= pwdata; // [R2] [R11]
         if (paddr == A_FLOWS) flows_r <= pwdata & 32'h0000_FFFF;
         if (paddr == A_CAP) cap_r <= pwdata & 32'h0000_00FF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_r <= 1'b0;
         reg_rd_r <= 32'h0000_0000;
      end else begin
         refused_r <= rif.ses_refused || (refused_r && !rif.ses_en);
         if (apb_setup) reg_rd_r <= reg_rd_nxt;
      end
   end

   // ==========================================================
   // Scrub walk
   mgqc_scrub_t sc_st_r;
   mgqc_scrub_t sc_st_nxt;
   logic [RIW-1:0] sc_idx_r;

   wire scrub_go = apb_wr && paddr == A_CTRL && pwdata[C_SCRUB];
   wire sc_last = sc_idx_r == RIW'(NR - 1);

   always_comb begin
      sc_st_nxt = sc_st_r;
      unique case (sc_st_r)
         SC_IDLE: if (scrub_go) sc_st_nxt = SC_RUN;
         SC_RUN: if (sc_last) sc_st_nxt = SC_IDLE;
         default: sc_st_nxt = SC_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc_st_r <= SC_IDLE;
         sc_idx_r <= '0;
      end else begin
         sc_st_r <= sc_st_nxt;
         sc_idx_r <= sc_st_r == SC_RUN ? sc_idx_r + RIW'(1) : '0;
      end
   end

   assign rif.scr_en = sc_st_r == SC_RUN; // [R9]
   assign rif.scr_idx = sc_idx_r;

   // ==========================================================
   // Classification
   wire take = pkt_valid && pkt_ready;
   assign pkt_ready = ctrl_r[C_EN] && sc_st_r == SC_IDLE;
   assign rif.mt_en = take && pkt_kind == KIND_JOIN;
   assign rif.mt_src = pkt_src;
   assign rif.mt_grp = pkt_grp;
   assign rif.mt_ds = pkt_ds;

   mgqc_rule_table #(.NR(NR)) u_tbl (
      .clk(pclk),
      .rst_n(presetn),
      .rif(rif.tbl)
   );

   logic s1_v;
   mgqc_kind_t s1_kind;
   logic [15:0] s1_len;
   logic [CHW-1:0] s1_chan;
   logic s1_bonded;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_v <= 1'b0;
         s1_kind <= KIND_JOIN;
         s1_len <= 16'h0000;
         s1_chan <= '0;
         s1_bonded <= 1'b0;
      end else begin
         s1_v <= take;
         s1_kind <= mgqc_kind_t'(pkt_kind);
         s1_len <= pkt_len;
         s1_chan <= pkt_chan;
         s1_bonded <= pkt_bonded;
      end
   end

   // ==========================================================
   // Default flow rate budget per channel
   logic [15:0] bud_r [NC];
   logic [15:0] win_r;

   wire [15:0] rate = defc_r[DC_RATE_LSB +: 16];
   wire win_end = win_r == 16'(WIN_CYC - 1);
   wire [15:0] cur_bud = bud_r[s1_chan];
   wire joined = s1_kind == KIND_JOIN; // [R12]
   wire unmatched = s1_v && joined && !rif.hit;
   wire over = cur_bud < s1_len;
   wire drop_nxt = unmatched && (s1_bonded || over); // [R4] [R6]
   wire charge = unmatched && !s1_bonded && !over;
   wire [7:0] def_flow = DEF_FLOW_BASE + 8'(s1_chan); // [R5]
   wire [7:0] other_flow = s1_kind == KIND_L2 ? flows_r[FL_L2_LSB +: 8] // [R13]
                                              : flows_r[FL_BC_LSB +: 8]; // [R14]
   wire [7:0] flow_nxt = !joined ? other_flow :
                         rif.hit ? rif.hit_flow : def_flow; // [R3] [R7] [R8]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) win_r <= 16'h0000;
      else win_r <= win_end ? 16'h0000 : win_r + 16'h0001;
   end

   for (genvar c = 0; c < NC; c++) begin : g_bud
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) bud_r[c] <= 16'h0000;
         else if (win_end) bud_r[c] <= rate; // [R6] [R11]
         else if (charge && s1_chan == CHW'(c)) bud_r[c] <= bud_r[c] - s1_len;
      end
   end

   // ==========================================================
   // Output stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_flow <= 8'h00;
         out_default <= 1'b0;
         out_drop <= 1'b0;
         out_chan <= '0;
         drops_r <= 32'h0000_0000;
      end else begin
         out_valid <= s1_v;
         out_flow <= flow_nxt;
         out_default <= unmatched;
         out_drop <= drop_nxt;
         out_chan <= s1_chan; // [R15]
         drops_r <= drops_r + 32'(drop_nxt);
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_unm_bond;
      s1_v && joined && !rif.hit && s1_bonded;
   endsequence
   sequence s_unm_single;
      unmatched && !s1_bonded && !over;
   endsequence
   sequence s_dropped;
      out_valid && out_drop && out_default;
   endsequence

   a_bond_drop: assert property (s_unm_bond |=> s_dropped) // [R4]
      else $error("unmatched bonded packet not dropped");
   a_def_flow: assert property (s_unm_single // [R3]
      |=> out_valid && !out_drop && out_flow == DEF_FLOW_BASE + 8'($past(s1_chan)))
      else $error("unmatched packet missed channel default flow");
   a_rate_cap: assert property (charge && !win_end // [R6]
      |=> bud_r[$past(s1_chan)] == $past(cur_bud) - $past(s1_len))
      else $error("default flow budget not charged");
   a_l2_flow: assert property (s1_v && s1_kind == KIND_L2 // [R13]
      |=> out_valid && !out_drop && out_flow == flows_r[FL_L2_LSB +: 8])
      else $error("layer two traffic left without group flow");
   a_hit_flow: assert property (s1_v && joined && rif.hit // [R7]
      |=> out_flow == $past(rif.hit_flow) && !out_default && !out_drop)
      else $error("classified packet not on its rule flow");
   a_scrub_stall: assert property (sc_st_r == SC_IDLE && scrub_go // [R9]
      |=> !pkt_ready [*8])
      else $error("packets taken during scrub");
   a_apb_err: assert property (apb_acc && !mapped
      |-> pslverr ##1 ($stable(ctrl_r) && $stable(defc_r) && $stable(cap_r)))
      else $error("unmapped access not flagged or not ignored");

endmodule : mgqc_top

// File: pkg/mgqc_pkg.sv
package mgqc_pkg;

   // ==========================================================
   // Sizes
   localparam int NRULE = 16;
   localparam int RIW = 4;
   localparam int NCH = 16;
   localparam int CHW = 4;

   // ==========================================================
   // Register offsets
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_DEFC = 12'h004;
   localparam logic [11:0] A_FLOWS = 12'h008;
   localparam logic [11:0] A_SESS = 12'h00C;
   localparam logic [11:0] A_DROPS = 12'h010;
   localparam logic [11:0] A_CAP = 12'h014;
   localparam logic [11:0] A_RULE = 12'h100;
   localparam logic [11:0] A_RULE_END = 12'h180;
   localparam logic [11:0] A_CNT = 12'h200;
   localparam logic [11:0] A_CNT_END = 12'h240;

   // ==========================================================
   // Field positions
   localparam int C_EN = 0;
   localparam int C_SCRUB = 1;
   localparam int DC_CLS_LSB = 0;
   localparam int DC_RATE_LSB = 16;
   localparam int FL_L2_LSB = 0;
   localparam int FL_BC_LSB = 8;
   localparam int SC_JOIN = 31;
   localparam int RA_VALID = 31;
   localparam int RA_AGG = 30;
   localparam int RA_FLOW_LSB = 16;
   localparam int RA_GRP_LSB = 8;
   localparam int RA_SRC_LSB = 0;
   localparam int RB_MASK_LSB = 16;
   localparam int RB_HI_LSB = 8;
   localparam int RB_LO_LSB = 0;

   // ==========================================================
   // Reset values and constants
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] DEFC_RST = 32'h0100_0001;
   localparam logic [31:0] FLOWS_RST = 32'h0000_7E7F;
   localparam logic [31:0] CAP_RST = 32'h0000_0004;
   localparam logic [7:0] DEF_FLOW_BASE = 8'h80;
   localparam logic [1:0] RD_A = 2'h0;
   localparam logic [1:0] RD_B = 2'h1;
   localparam logic [1:0] RD_CNT = 2'h2;

   // ==========================================================
   // Timing
   localparam int CLK_NS = 4;
   localparam int WIN_NS = 1000;
   localparam int WIN_CYC = WIN_NS / CLK_NS;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      KIND_JOIN = 2'h0,
      KIND_L2 = 2'h1,
      KIND_L3B = 2'h2,
      KIND_LOCAL = 2'h3
   } mgqc_kind_t;

   typedef enum logic [1:0] {
      SC_IDLE = 2'h1,
      SC_RUN = 2'h2
   } mgqc_scrub_t;

endpackage : mgqc_pkg

// File: pkg/mgqc_rule_if.sv
`timescale 1ns/10ps
interface mgqc_rule_if import mgqc_pkg::*; ();
   logic wr_en;
   logic wr_word;
   logic [RIW-1:0] wr_idx;
   logic [31:0] wr_data;
   logic [RIW-1:0] rd_idx;
   logic [1:0] rd_word;
   logic [31:0] rd_data;
   logic scr_en;
   logic [RIW-1:0] scr_idx;
   logic ses_en;
   logic ses_join;
   logic [RIW-1:0] ses_idx;
   logic [7:0] cap;
   logic ses_refused;
   logic mt_en;
   logic [7:0] mt_src;
   logic [7:0] mt_grp;
   logic [7:0] mt_ds;
   logic hit;
   logic [7:0] hit_flow;

   modport ctl (
      output wr_en, wr_word, wr_idx, wr_data, rd_idx, rd_word, scr_en, scr_idx,
      output ses_en, ses_join, ses_idx, cap, mt_en, mt_src, mt_grp, mt_ds,
      input rd_data, ses_refused, hit, hit_flow
   );
   modport tbl (
      input wr_en, wr_word, wr_idx, wr_data, rd_idx, rd_word, scr_en, scr_idx,
      input ses_en, ses_join, ses_idx, cap, mt_en, mt_src, mt_grp, mt_ds,
      output rd_data, ses_refused, hit, hit_flow
   );
endinterface : mgqc_rule_if

// File: testbench/mgqc_chan_sink.sv
`timescale 1ns/10ps
// ==========================================================
// Channel side sink: counts every packet carried on a flow
module mgqc_chan_sink import mgqc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic out_valid,
   input wire logic out_drop,
   input wire logic [7:0] out_flow,
   input wire logic [CHW-1:0] out_chan,
   output logic [15:0] carried
);
   logic [15:0] carried_r;
   logic [7:0] last_flow_r [NCH];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carried_r <= 16'h0000;
         for (int k = 0; k < NCH; k++) begin
            last_flow_r[k] <= 8'h00;
         end
      end else if (out_valid && !out_drop) begin
         carried_r <= carried_r + 16'h0001;
         last_flow_r[out_chan] <= out_flow;
      end
   end
   assign carried = carried_r;
endmodule : mgqc_chan_sink

// File: testbench/mgqc_top_tb.sv
`timescale 1ns/10ps
module mgqc_top_tb import mgqc_pkg::*; ;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, seed;
   logic pkt_valid, pkt_ready, pkt_bonded, e, r2_live;
   logic [1:0] pkt_kind;
   logic [7:0] pkt_src, pkt_grp, pkt_ds, out_flow;
   logic [15:0] pkt_len, rate, carried;
   logic [3:0] pkt_chan, out_chan;
   logic out_valid, out_default, out_drop;
   logic [13:0] exp_q[$];
   logic [13:0] got;
   int mismatches, samples_checked, n_drop, n_carry;

   mgqc_top i_mgqc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_kind(pkt_kind),
      .pkt_src(pkt_src), .pkt_grp(pkt_grp), .pkt_ds(pkt_ds), .pkt_len(pkt_len),
      .pkt_chan(pkt_chan), .pkt_bonded(pkt_bonded), .out_valid(out_valid),
      .out_flow(out_flow), .out_default(out_default), .out_drop(out_drop), .out_chan(out_chan));
   mgqc_chan_sink i_mgqc_chan_sink (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
      .out_drop(out_drop), .out_flow(out_flow), .out_chan(out_chan), .carried(carried));

   always #2 pclk = ~pclk;

   // ==========================================================
   // Checking
   task check(input string nm, input logic [31:0] seen, input logic [31:0] x);
      samples_checked++;
      if (seen !== x) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, x, seen);
      end
   endtask : check

   task end_sim;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   function logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs

   function logic [13:0] expect_of(input logic [1:0] k, input logic [7:0] s, g, d,
      input logic [15:0] n, input logic [3:0] c, input logic b);
      logic [7:0] f;
      logic dflt, drp;
      dflt = 1'b0;
      drp = 1'b0;
      if (k == 2'h1) f = 8'h7F;
      else if (k != 2'h0) f = 8'h7E;
      else if (s == 8'h09 && g == 8'h0A && d == 8'h06) f = 8'h10;
      else if (d == 8'h01) f = 8'h20;
      else if (r2_live && s == 8'h03 && g == 8'h04 && (d & 8'h0F) >= 8'h02
         && (d & 8'h0F) <= 8'h03) f = 8'h30;
      else begin
         dflt = 1'b1;
         f = DEF_FLOW_BASE + {4'h0, c};
         drp = b || (n > rate);
      end
      return {drp, dflt, c, f};
   endfunction : expect_of

   // ==========================================================
   // Drivers
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(a, 1'b0, 32'h0000_0000);
      check($sformatf("reg_%h", a), r, x);
   endtask : rd

   task send(input logic [1:0] k, input logic [7:0] s, g, d, input logic [15:0] n,
      input logic [3:0] c, input logic b);
      logic [13:0] x;
      pkt_valid <= 1'b1;
      pkt_kind <= k;
      pkt_src <= s;
      pkt_grp <= g;
      pkt_ds <= d;
      pkt_len <= n;
      pkt_chan <= c;
      pkt_bonded <= b;
      @(posedge pclk);
      while (pkt_ready !== 1'b1) @(posedge pclk);
      x = expect_of(k, s, g, d, n, c, b);
      exp_q.push_back(x);
      if (x[13]) n_drop++;
      else n_carry++;
   endtask : send

   // ==========================================================
   // Output monitor
   always @(posedge pclk) begin
      if (out_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("stray_out", 32'h0000_0001, 32'h0000_0000);
         end else begin
            got = exp_q.pop_front();
            check("out_drop", out_drop, got[13]);
            check("out_default", out_default, got[12]);
            check("out_chan", out_chan, got[11:8]);
            if (!got[13]) check("out_flow", out_flow, got[7:0]);
         end
      end
   end

   initial begin
      repeat (30000) @(posedge pclk);
      mismatches++;
      end_sim();
   end

   // ==========================================================
   // Main sequence
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 12'h000; pwdata = 32'h0000_0000; pkt_valid = 0; pkt_kind = 2'h0;
      pkt_src = 8'h00; pkt_grp = 8'h00; pkt_ds = 8'h00; pkt_len = 16'h0000;
      pkt_chan = 4'h0; pkt_bonded = 0; r2_live = 1; rate = 16'h0100;
      seed = 32'h0000_0037;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_CTRL, CTRL_RST);
      rd(A_DEFC, DEFC_RST);
      rd(A_FLOWS, FLOWS_RST);
      rd(A_CAP, CAP_RST);
      rd(A_DROPS, 32'h0000_0000);
      apb(12'h020, 1'b0, 32'h0000_0000);
      check("unmapped_err", e, 1'b1);
      apb(12'h002, 1'b1, 32'h0000_0000);
      check("misaligned_err", e, 1'b1);
      apb(A_RULE, 1'b1, 32'h8010_0A09);
      apb(A_RULE + 12'h004, 1'b1, 32'h00FF_0606);
      apb(A_RULE + 12'h008, 1'b1, 32'hC020_0000);
      apb(A_RULE + 12'h00C, 1'b1, 32'h00FF_0101);
      apb(A_RULE + 12'h010, 1'b1, 32'h8030_0403);
      apb(A_RULE + 12'h014, 1'b1, 32'h000F_0302);
      apb(A_CAP, 1'b1, 32'h0000_0002);
      apb(A_SESS, 1'b1, 32'h8000_0000);
      rd(A_SESS, 32'h0000_0000);
      apb(A_SESS, 1'b1, 32'h8000_0000);
      rd(A_SESS, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         apb(A_SESS, 1'b1, 32'h8000_0001);
         rd(A_SESS, (i == 2) ? 32'h0000_0001 : 32'h0000_0000);
      end
      rd(A_CNT + 12'h004, 32'h0000_0002);
      repeat (260) @(posedge pclk);
      send(2'h0, 8'h09, 8'h0A, 8'h06, 16'h0001, 4'h3, 1'b0);
      send(2'h0, 8'h09, 8'h0A, 8'h05, 16'h0001, 4'h3, 1'b0);
      send(2'h0, 8'h09, 8'h0A, 8'h06, 16'h0001, 4'h4, 1'b1);
      send(2'h0, 8'h07, 8'h07, 8'h01, 16'h0001, 4'h5, 1'b0);
      send(2'h0, 8'h08, 8'h08, 8'h01, 16'h0001, 4'h6, 1'b1);
      send(2'h0, 8'h03, 8'h04, 8'hF2, 16'h0001, 4'h7, 1'b0);
      send(2'h0, 8'h03, 8'h04, 8'hF4, 16'h0001, 4'h7, 1'b0);
      send(2'h0, 8'h09, 8'h0B, 8'h06, 16'h0001, 4'h8, 1'b1);
      send(2'h0, 8'h01, 8'h02, 8'h09, 16'h012C, 4'h9, 1'b0);
      send(2'h1, 8'h01, 8'h02, 8'h06, 16'h0001, 4'hA, 1'b1);
      send(2'h2, 8'h09, 8'h0A, 8'h06, 16'h0001, 4'hB, 1'b0);
      send(2'h3, 8'h09, 8'h0A, 8'h01, 16'h0001, 4'hC, 1'b0);
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         send(seed[26:25], seed[7:0], seed[15:8], seed[16] ? 8'h01 : seed[31:24],
            16'h0001, seed[23:20], seed[17]);
      end
      pkt_valid <= 1'b0;
      @(posedge pclk);
      apb(A_DEFC, 1'b1, 32'h0004_0001);
      rate = 16'h0004;
      repeat (260) @(posedge pclk);
      send(2'h0, 8'h01, 8'h02, 8'h09, 16'h0005, 4'h2, 1'b0);
      send(2'h0, 8'h01, 8'h02, 8'h09, 16'h0004, 4'h3, 1'b0);
      pkt_valid <= 1'b0;
      @(posedge pclk);
      r2_live = 1'b0;
      apb(A_CTRL, 1'b1, 32'h0000_0003);
      check("ready_in_scrub", pkt_ready, 1'b0);
      send(2'h0, 8'h03, 8'h04, 8'hF2, 16'h0001, 4'h7, 1'b0);
      send(2'h0, 8'h09, 8'h0A, 8'h06, 16'h0001, 4'h7, 1'b0);
      pkt_valid <= 1'b0;
      @(posedge pclk);
      apb(A_RULE + 12'h010, 1'b0, 32'h0000_0000);
      check("rule2_valid", r[RA_VALID], 1'b0);
      apb(A_RULE, 1'b0, 32'h0000_0000);
      check("rule0_valid", r[RA_VALID], 1'b1);
      rd(A_DROPS, n_drop);
      repeat (10) @(posedge pclk);
      check("pending", exp_q.size(), 32'h0000_0000);
      check("carried", carried, n_carry);
      check("sink_flow", i_mgqc_chan_sink.last_flow_r[7], 32'h0000_0010);
      end_sim();
   end
endmodule : mgqc_top_tb
